// ---- verilog/arc_pkg.sv ----
// Package with register map, field layout and types of the converter registers.
package arc_pkg;
  localparam logic [11:0] ARC_OFS_RESULT_HIGH = 12'h000;
  localparam logic [11:0] ARC_OFS_RESULT_LOW  = 12'h004;
  localparam logic [11:0] ARC_OFS_CMP_HIGH    = 12'h008;
  localparam logic [11:0] ARC_OFS_CMP_LOW     = 12'h00C;
  localparam logic [11:0] ARC_OFS_CONFIG      = 12'h010;
  localparam logic [11:0] ARC_OFS_PIN_SEL     = 12'h014;
  localparam logic [11:0] ARC_OFS_CMP_CTRL    = 12'h018;

  localparam int ARC_CFG_LOW_POWER_BIT = 7;
  localparam int ARC_CFG_DIV_LSB       = 5;
  localparam int ARC_CFG_LONG_SMP_BIT  = 4;
  localparam int ARC_CFG_MODE_LSB      = 2;
  localparam int ARC_CFG_ICLK_LSB      = 0;
  localparam int ARC_CTRL_ENABLE_BIT   = 0;
  localparam int ARC_CTRL_GE_BIT       = 1;

  localparam logic [7:0] ARC_RST_CONFIG  = 8'h00;
  localparam logic [7:0] ARC_RST_CMP     = 8'h00;
  localparam logic [7:0] ARC_RST_PIN_SEL = 8'h00;
  localparam logic [7:0] ARC_RST_RESULT  = 8'h00;
  localparam logic [1:0] ARC_RST_CTRL    = 2'h0;

  typedef enum logic [1:0] {
    ARC_MODE_8BIT  = 2'b00,
    ARC_MODE_RSV1  = 2'b01,
    ARC_MODE_10BIT = 2'b10,
    ARC_MODE_RSV3  = 2'b11
  } arc_mode_t;

  typedef enum logic [1:0] {
    ARC_CLK_BUS      = 2'b00,
    ARC_CLK_BUS_DIV2 = 2'b01,
    ARC_CLK_ALT      = 2'b10,
    ARC_CLK_ASYNC    = 2'b11
  } arc_clk_src_t;

  typedef enum logic [1:0] {
    ARC_LOCK_OPEN = 2'b00,
    ARC_LOCK_HELD = 2'b01
  } arc_lock_t;

  typedef struct packed {
    logic         low_power_select;
    logic [1:0]   clock_divide_select;
    logic         long_sample_select;
    arc_mode_t    mode;
    arc_clk_src_t input_clock_select;
  } arc_cfg_t;

  typedef struct packed {
    logic       valid;
    logic [9:0] value;
  } arc_sample_t;

  // Divide ratio decoded from the two-bit divide field.
  function automatic logic [3:0] arc_div_ratio(input logic [1:0] sel);
    arc_div_ratio = 4'h1 << sel;
  endfunction
endpackage

// ---- verilog/arc_compare.sv ----
// Compare unit deciding whether a finished conversion may be stored.
`timescale 1ns/1ps
`default_nettype none
module arc_compare
  import arc_pkg::*;
(
  input  wire logic       enable,
  input  wire logic       greater_equal,
  input  wire arc_mode_t  mode,
  input  wire logic [9:0] result,
  input  wire logic [1:0] cmp_high,
  input  wire logic [7:0] cmp_low,
  output logic            store_ok
);
  wire        is_10bit = (mode == ARC_MODE_10BIT);
  // Upper bits join the compare only in 10-bit mode.
  wire [9:0]  lhs = is_10bit ? result : {2'b00, result[7:0]};    // R8 R17
  wire [9:0]  rhs = is_10bit ? {cmp_high, cmp_low} : {2'b00, cmp_low}; // R7
  wire        ge  = (lhs >= rhs);
  wire        hit = greater_equal ? ge : !ge;
  assign store_ok = !enable || hit;    // R2
endmodule // arc_compare
`default_nettype wire

// ---- verilog/arc_clock_gen.sv ----
// Converter clock enable generator from source select and divider.
`timescale 1ns/1ps
`default_nettype none
module arc_clock_gen
  import arc_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire arc_clk_src_t input_clock_select,
  input  wire logic [1:0]   clock_divide_select,
  input  wire logic         alternate_clock,
  input  wire logic         internal_async_clock,
  output logic              converter_clock
);
  logic       half;
  logic [2:0] count;
  logic       alt_q;
  logic       async_q;
  logic       conv;

  // Sources are sampled as ordinary inputs; each rising edge is one tick.
  wire alt_tick   = alternate_clock && !alt_q;
  wire async_tick = internal_async_clock && !async_q;
  wire src_tick   = (input_clock_select == ARC_CLK_BUS)      ? 1'b1 :
                    (input_clock_select == ARC_CLK_BUS_DIV2) ? half :
                    (input_clock_select == ARC_CLK_ALT)      ? alt_tick :
                                                               async_tick; // R13
  wire [3:0] ratio = arc_div_ratio(clock_divide_select);
  wire       wrap  = ({1'b0, count} == ratio - 4'h1);              // R10

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      half    <= 1'b0;
      count   <= 3'h0;
      alt_q   <= 1'b0;
      async_q <= 1'b0;
      conv    <= 1'b0;
    end
    else
    begin
      half    <= !half;
      alt_q   <= alternate_clock;
      async_q <= internal_async_clock;
      conv    <= src_tick && wrap;
      if (src_tick)
        count <= wrap ? 3'h0 : count + 3'h1;                        // R10
    end
  end
  assign converter_clock = conv;
endmodule // arc_clock_gen
`default_nettype wire

// ---- verilog/arc_regs.sv ----
// Converter result, compare and configuration registers behind APB.
//
// Contract
// R1 - The low result holds result bits 7 to 0, the whole result in 8-bit mode.
// R2 - Results load at each completion unless compare is on and its test fails.
// R3 - In 10-bit mode a high-result read blocks loads until a low-result read.
// R4 - Completions arriving while blocked are dropped.
// R5 - In 8-bit mode there is no interlock and every result may load.
// R6 - Software treats the low result as invalid after a width change.
// R7 - Compare-high bits join the compare only in 10-bit mode.
// R8 - Compare-low bits are tested against result bits 7 to 0 in both modes.
// R9 - Config bit 7 selects high speed (0) or low power (1).
// R10 - Config bits 6:5 divide the input clock by 1, 2, 4 or 8.
// R11 - Config bit 4 selects short (0) or long (1) sampling.
// R12 - Config bits 3:2 select 8-bit (00) or 10-bit (10); others reserved.
// R13 - Config bits 1:0 select bus, bus/2, alternate or internal clock.
// R14 - Pin select bit n takes channel n's pin from the port when set.
// R15 - A selected pin is tri-stated, input and pullup off, port reads zero.
// R16 - After reset the input clock selection is the bus clock.
// R17 - The store decision uses the compare at the selected result width.
//
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module arc_regs
  import arc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire arc_sample_t conv_done,
  input  wire logic        alternate_clock,
  input  wire logic        internal_async_clock,
  output logic             converter_clock,
  output arc_cfg_t         config_out,
  output logic [7:0]       port_out_en,
  input  wire logic [7:0]  port_out_en_req,
  output logic [7:0]       port_in_en,
  output logic [7:0]       port_pullup_en,
  input  wire logic [7:0]  port_pullup_req,
  input  wire logic [7:0]  port_pin_in,
  output logic [7:0]       port_read
);
  arc_cfg_t    cfg;
  logic [7:0]  result_low;
  logic [1:0]  result_high;
  logic [7:0]  compare_value_high;
  logic [7:0]  compare_value_low;
  logic [7:0]  analog_pin_select_low;
  logic [1:0]  cmp_ctrl;
  arc_lock_t   lock;
  arc_lock_t   next_lock;
  logic [31:0] rdata;
  logic        store_ok;

  // Decode of the APB access phase.
  wire access = psel && penable;
  wire wr     = access && pwrite;
  wire rd     = access && !pwrite;
  wire hit_rh = (paddr == ARC_OFS_RESULT_HIGH);
  wire hit_rl = (paddr == ARC_OFS_RESULT_LOW);
  wire hit_ch = (paddr == ARC_OFS_CMP_HIGH);
  wire hit_cl = (paddr == ARC_OFS_CMP_LOW);
  wire hit_cf = (paddr == ARC_OFS_CONFIG);
  wire hit_ps = (paddr == ARC_OFS_PIN_SEL);
  wire hit_cc = (paddr == ARC_OFS_CMP_CTRL);
  wire mapped = hit_rh | hit_rl | hit_ch | hit_cl | hit_cf | hit_ps | hit_cc;

  wire is_10bit   = (cfg.mode == ARC_MODE_10BIT);
  wire rd_high    = rd && hit_rh;
  wire rd_low     = rd && hit_rl;
  wire blocked    = is_10bit && (lock == ARC_LOCK_HELD);         // R3 R5
  // A completion is dropped outright while blocked, not held back.
  wire load       = conv_done.valid && store_ok && !blocked;     // R2 R4

  arc_compare i_arc_compare (
    .enable        (cmp_ctrl[ARC_CTRL_ENABLE_BIT]),
    .greater_equal (cmp_ctrl[ARC_CTRL_GE_BIT]),
    .mode          (cfg.mode),
    .result        (conv_done.value),
    .cmp_high      (compare_value_high[1:0]),
    .cmp_low       (compare_value_low),
    .store_ok      (store_ok)
  );

  arc_clock_gen i_arc_clock_gen (
    .ref_clk              (ref_clk),
    .srst                 (srst),
    .input_clock_select   (cfg.input_clock_select),
    .clock_divide_select  (cfg.clock_divide_select),
    .alternate_clock      (alternate_clock),
    .internal_async_clock (internal_async_clock),
    .converter_clock      (converter_clock)
  );

  // Lock: set by a high read in 10-bit mode, released by a low read.
  always_comb
  begin
    next_lock = lock;
    unique case (lock)
      ARC_LOCK_OPEN:
        if (rd_high && is_10bit && !rd_low)
          next_lock = ARC_LOCK_HELD;                               // R3
      ARC_LOCK_HELD:
        if (rd_low || !is_10bit)
          next_lock = ARC_LOCK_OPEN;                               // R3 R5
      default:
        next_lock = ARC_LOCK_OPEN;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      lock <= ARC_LOCK_OPEN;
    else
      lock <= next_lock;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      result_low  <= ARC_RST_RESULT;
      result_high <= ARC_RST_RESULT[1:0];
    end
    else if (load)
    begin
      result_low  <= conv_done.value[7:0];                         // R1
      result_high <= is_10bit ? conv_done.value[9:8] : 2'b00;      // R1
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      cfg                   <= arc_cfg_t'(ARC_RST_CONFIG);         // R16
      compare_value_high    <= ARC_RST_CMP;
      compare_value_low     <= ARC_RST_CMP;
      analog_pin_select_low <= ARC_RST_PIN_SEL;
      cmp_ctrl              <= ARC_RST_CTRL;
    end
    else if (wr)
    begin
      if (hit_cf)
        cfg <= arc_cfg_t'(pwdata[7:0]);                    // R9 R10 R11 R12 R13
      if (hit_ch)
        compare_value_high <= {6'h00, pwdata[1:0]};                // R7
      if (hit_cl)
        compare_value_low <= pwdata[7:0];                          // R8
      if (hit_ps)
        analog_pin_select_low <= pwdata[7:0];                      // R14
      if (hit_cc)
        cmp_ctrl <= pwdata[1:0];
    end
  end

  // Read multiplexer; unmapped addresses read zero with an error.
  wire [31:0] mux_rd =
    hit_rh ? {30'h0, result_high} :
    hit_rl ? {24'h0, result_low} :
    hit_ch ? {24'h0, compare_value_high} :
    hit_cl ? {24'h0, compare_value_low} :
    hit_cf ? {24'h0, cfg} :
    hit_ps ? {24'h0, analog_pin_select_low} :
    hit_cc ? {30'h0, cmp_ctrl} : 32'h0;

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      rdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      rdata <= mux_rd;
  end

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = rdata;

  assign config_out     = cfg;                         // R9 R10 R11 R12 R13
  assign port_out_en    = port_out_en_req & ~analog_pin_select_low; // R14 R15
  assign port_in_en     = ~analog_pin_select_low;                   // R15
  assign port_pullup_en = port_pullup_req & ~analog_pin_select_low; // R15
  assign port_read      = port_pin_in & ~analog_pin_select_low;     // R15
endmodule // arc_regs
`default_nettype wire

// ---- verification/arc_regs_chk.sv ----
// Assertion checker for the converter register block ports.
`timescale 1ns/1ps
`default_nettype none
module arc_regs_chk
  import arc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire arc_cfg_t    config_out,
  input wire logic [7:0]  port_out_en,
  input wire logic [7:0]  port_out_en_req,
  input wire logic [7:0]  port_in_en,
  input wire logic [7:0]  port_pullup_en,
  input wire logic [7:0]  port_pullup_req,
  input wire logic [7:0]  port_pin_in,
  input wire logic [7:0]  port_read
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic       wr_acc;
  logic       cfg_wr;
  logic       pin_wr;
  logic [7:0] wbyte;
  assign wr_acc = psel && penable && pwrite;
  assign cfg_wr = wr_acc && paddr == ARC_OFS_CONFIG;
  assign pin_wr = wr_acc && paddr == ARC_OFS_PIN_SEL;
  assign wbyte  = pwdata[7:0];
  a_out_req: assert property (port_out_en == (port_out_en_req & port_in_en))
    else $error("output enable not masked by pin select");
  a_pull_mask: assert property (port_pullup_en == (port_pullup_req & port_in_en))
    else $error("pullup enable not masked by pin select");
  a_read_mask: assert property (port_read == (port_pin_in & port_in_en))
    else $error("port read not zero on analog pin");
  a_pin_write: assert property (pin_wr |=> port_in_en == ~$past(wbyte))
    else $error("pin select write not applied");
  a_pin_hold: assert property (!pin_wr |=> $stable(port_in_en))
    else $error("pin select changed without write");
  a_cfg_write: assert property (cfg_wr |=> config_out == $past(wbyte))
    else $error("config write not applied");
  a_cfg_hold: assert property (!cfg_wr |=> $stable(config_out))
    else $error("config changed without write");
  a_rst_clk: assert property ($fell(srst) |-> config_out.input_clock_select == ARC_CLK_BUS)
    else $error("clock source not bus clock after reset");
  c_cfg: cover property (cfg_wr);
  c_pin: cover property (pin_wr);
  c_low_read: cover property (psel && !pwrite && paddr == ARC_OFS_RESULT_LOW);
endmodule // arc_regs_chk
`default_nettype wire

// ---- verification/tb_arc_regs.sv ----
// Self-checking testbench for the converter register block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module tb_arc_regs
  import arc_pkg::*;
;
  logic        ref_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic        alternate_clock, internal_async_clock, converter_clock;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  arc_sample_t conv_done;
  arc_cfg_t    config_out;
  logic [7:0]  port_out_en, port_out_en_req, port_in_en, port_pullup_en;
  logic [7:0]  port_pullup_req, port_pin_in, port_read;
  int          n_errors, n_tests, n;
  localparam logic [11:0] RA[6] = '{ARC_OFS_CMP_HIGH, ARC_OFS_CMP_LOW,
    ARC_OFS_CONFIG, ARC_OFS_PIN_SEL, ARC_OFS_RESULT_LOW, 12'h020};
  localparam logic [7:0] RW[6] = '{8'hFF, 8'hFF, 8'hF9, 8'h5A, 8'hFF, 8'hFF};
  localparam logic [7:0] RE[6] = '{8'h03, 8'hFF, 8'hF9, 8'h5A, 8'h00, 8'h00};
  // Clock rows: config value and converter ticks expected in 64 cycles.
  localparam logic [7:0] CD[6] = '{8'h02, 8'h03, 8'h20, 8'h40, 8'h60, 8'h61};
  localparam int         CE[6] = '{8, 16, 32, 16, 8, 4};
  arc_regs i_arc_regs (.*);
  initial
  begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic conclude;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    `CHK(pslverr, a == 12'h020)
    psel <= 1'b0; penable <= 1'b0;
    // One idle edge, so the next call never reassigns psel in this step.
    @(posedge ref_clk);
    if (k >= 50)
    begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK(q[7:0], e)
  endtask
  task automatic conv(input logic [9:0] v);
    conv_done <= {1'b1, v};
    @(posedge ref_clk);
    conv_done.valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  initial
  begin
    srst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    conv_done = '0; alternate_clock = 0; internal_async_clock = 0;
    port_out_en_req = 8'hFF; port_pullup_req = 8'hFF; port_pin_in = 8'hFF;
    n_errors = 0; n_tests = 0;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    `CHK(config_out.input_clock_select, ARC_CLK_BUS)
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, RA[i], RW[i]);
      rdc(RA[i], RE[i]);
      if (RA[i] == ARC_OFS_CONFIG)
        `CHK(config_out, RE[i])
    end
    `CHK({port_out_en, port_pullup_en, port_read, port_in_en}, 32'hA5A5A5A5)
    $display("test registers done");
    apb(1'b1, ARC_OFS_CONFIG, 8'h00);
    conv(10'h2A5); rdc(ARC_OFS_RESULT_LOW, 8'hA5);
    rdc(ARC_OFS_RESULT_HIGH, 8'h00); conv(10'h0C3);
    rdc(ARC_OFS_RESULT_LOW, 8'hC3);
    $display("test 8-bit results done");
    apb(1'b1, ARC_OFS_CONFIG, 8'h08);
    conv(10'h2A5); rdc(ARC_OFS_RESULT_HIGH, 8'h02);
    conv(10'h155); rdc(ARC_OFS_RESULT_LOW, 8'hA5);
    conv(10'h155); rdc(ARC_OFS_RESULT_HIGH, 8'h01);
    rdc(ARC_OFS_RESULT_LOW, 8'h55);
    $display("test interlock done");
    apb(1'b1, ARC_OFS_CMP_HIGH, 8'h01); apb(1'b1, ARC_OFS_CMP_LOW, 8'h00);
    apb(1'b1, ARC_OFS_CMP_CTRL, 8'h01);
    conv(10'h0FF); conv(10'h1FF); rdc(ARC_OFS_RESULT_HIGH, 8'h00);
    rdc(ARC_OFS_RESULT_LOW, 8'hFF);
    apb(1'b1, ARC_OFS_CMP_CTRL, 8'h03);
    conv(10'h200); conv(10'h0FF); rdc(ARC_OFS_RESULT_HIGH, 8'h02);
    rdc(ARC_OFS_RESULT_LOW, 8'h00);
    apb(1'b1, ARC_OFS_CONFIG, 8'h00); apb(1'b1, ARC_OFS_CMP_LOW, 8'h40);
    conv(10'h0A0); apb(1'b1, ARC_OFS_CMP_CTRL, 8'h01);
    conv(10'h050); rdc(ARC_OFS_RESULT_LOW, 8'hA0);
    conv(10'h320); rdc(ARC_OFS_RESULT_LOW, 8'h20);
    $display("test compare done");
    for (int d = 0; d < 6; d++)
    begin
      apb(1'b1, ARC_OFS_CONFIG, CD[d]);
      n = 0;
      // Alternate source rises every 8 cycles, internal one every 4.
      for (int c = 0; c < 80; c++)
      begin
        @(posedge ref_clk);
        alternate_clock      <= c[2];
        internal_async_clock <= c[1];
        @(negedge ref_clk);
        if (c >= 16 && converter_clock === 1'b1)
          n++;
      end
      @(posedge ref_clk);
      `CHK(n, CE[d])
    end
    $display("test clock divide done");
    srst <= 1'b1;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    rdc(ARC_OFS_CONFIG, 8'h00);
    `CHK(port_in_en, 8'hFF)
    $display("test reset done");
    conclude();
  end
endmodule // tb_arc_regs
bind arc_regs arc_regs_chk i_arc_regs_chk (.*);
`default_nettype wire
